// file: inc/crl_defines.svh
// Offsets, field positions, reset values and counts of the code lock block
`ifndef CRL_DEFINES_SVH
`define CRL_DEFINES_SVH

// Code image layout for the 8k part
`define CRL_ROM_TOP        16'h1fff
`define CRL_KEY_BASE       16'h2000
`define CRL_KEY_LAST       16'h203f
`define CRL_LOCK_ADDR      16'h2040
`define CRL_ROM_AW         13

// Key store
`define CRL_KEY_BYTES      64
`define CRL_KEY_IW         6
`define CRL_KEY_RESET      8'hff
`define CRL_KEY_LAST_IDX   6'h3f

// Lock option byte fields, 0 enables protection
`define CRL_LOCK1_BIT      0
`define CRL_LOCK2_BIT      1
`define CRL_LOCK_RESET     8'hff

// Register byte offsets
`define CRL_REG_STATUS     32'h0000_0000
`define CRL_REG_CONTROL    32'h0000_0004
`define CRL_REG_EVENTS     32'h0000_0008
`define CRL_ADDR_LSB       2
`define CRL_ADDR_MSB       11

// Status fields
`define CRL_ST_LOCK1       0
`define CRL_ST_LOCK2       1
`define CRL_ST_ENCRYPT     2
`define CRL_ST_XSEL        3
`define CRL_ST_LOADED      4
`define CRL_ST_BADCOMBO    5

// Control fields and reset value
`define CRL_CT_PROG_EN     0
`define CRL_CT_VER_EN      1
`define CRL_CONTROL_RESET  2'h2

// Event fields, write one to clear
`define CRL_EV_PROG_REF    0
`define CRL_EV_VER_DEN     1
`define CRL_EV_TBL_BLK     2

// AXI responses
`define CRL_RESP_OKAY      2'h0
`define CRL_RESP_SLVERR    2'h2

`endif

// file: inc/crl_pkg.sv
// Types shared by the code lock block
package crl_pkg;

	// Load and run sequence, one-hot
	typedef enum logic [4:0] {
		CRL_S_KEY_REQ  = 5'h01,
		CRL_S_KEY_WAIT = 5'h02,
		CRL_S_LCK_REQ  = 5'h04,
		CRL_S_LCK_WAIT = 5'h08,
		CRL_S_RUN      = 5'h10
	} crl_state_t;

	// Decoded protection state
	typedef struct packed {
		logic lock1;
		logic lock2;
		logic bad_combo;
	} crl_lock_t;

	// Verify request carried through the read pipeline
	typedef struct packed {
		logic        denied;
		logic [7:0]  key;
	} crl_ver_t;

endpackage

// file: rtl/crl_key_store.sv
// Flip-flop store for the 64 scrambling key bytes
`timescale 1ns/1ps
`include "crl_defines.svh"

module crl_key_store (
	// Clock and reset
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	// Load port
	input  wire logic                    wr_en,
	input  wire logic [`CRL_KEY_IW-1:0]  wr_idx,
	input  wire logic [7:0]              wr_data,
	// Lookup port
	input  wire logic [`CRL_KEY_IW-1:0]  rd_idx,
	output logic      [7:0]              rd_data,
	output logic                         any_programmed
);

	logic [7:0] key_mem [`CRL_KEY_BYTES];
	logic [`CRL_KEY_BYTES-1:0] byte_prog;

	// Unprogrammed key is all ones, which leaves data unchanged
	always_ff @(posedge aclk) begin
		for (int i = 0; i < `CRL_KEY_BYTES; i++) begin
			if (!aresetn) begin
				key_mem[i] <= `CRL_KEY_RESET;
			end else if (wr_en && wr_idx == i[`CRL_KEY_IW-1:0]) begin
				key_mem[i] <= wr_data;
			end
		end
	end

	// Any byte not all ones sets any_programmed, the scrambling status flag
	always_comb begin
		for (int i = 0; i < `CRL_KEY_BYTES; i++) begin
			byte_prog[i] = (key_mem[i] != `CRL_KEY_RESET);
		end
	end

	assign rd_data        = key_mem[rd_idx];
	assign any_programmed = |byte_prog;

endmodule

// file: rtl/crl_top.sv
// Code memory lock, verify scrambling and AXI4-Lite status block
`timescale 1ns/1ps
`include "crl_defines.svh"

module crl_top (
	// Clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// AXI4-Lite slave
	input  wire logic [31:0]  s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [31:0]  s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	// Nonvolatile option store, data within the request cycle
	output logic              nvm_req,
	output logic [15:0]       nvm_addr,
	input  wire logic [7:0]   nvm_data,
	// External access pin, asynchronous
	input  wire logic         ext_access_pin,
	output logic              external_access_select,
	// CPU code table read fetch check
	input  wire logic         code_table_read_instruction,
	input  wire logic         fetch_from_external,
	output logic              table_read_block,
	// Verify port
	input  wire logic         ver_req,
	input  wire logic [15:0]  ver_addr,
	output logic              ver_ready,
	output logic              ver_valid,
	output logic [7:0]        ver_data,
	output logic              ver_denied,
	// Code memory read port, data in the same cycle as the address
	output logic [`CRL_ROM_AW-1:0] rom_addr,
	input  wire logic [7:0]   rom_data,
	// Programming port
	input  wire logic         prog_req,
	input  wire logic [15:0]  prog_addr,
	input  wire logic [7:0]   prog_data,
	output logic              prog_ack,
	output logic              prog_refused,
	output logic              code_wr_en,
	output logic [15:0]       code_wr_addr,
	output logic [7:0]        code_wr_data
);

	crl_pkg::crl_state_t state;
	crl_pkg::crl_state_t next_state;
	crl_pkg::crl_lock_t  lock;
	crl_pkg::crl_ver_t   ver_q;
	logic [`CRL_KEY_IW-1:0] load_idx;
	logic [7:0] lock_byte;
	logic       ext_s1;
	logic       ext_s2;
	logic       ext_latched;
	logic       running;
	logic       key_wr;
	logic [7:0] key_byte;
	logic       key_any;
	logic       ver_pend;
	logic       ver_take;
	logic       ver_blk;
	logic       prog_ok;
	logic [1:0] control;
	logic [2:0] events;
	logic [2:0] ev_set;
	logic       aw_held;
	logic       w_held;
	logic [31:0] aw_q;
	logic [31:0] w_q;
	logic [3:0]  ws_q;
	logic        wr_do;
	logic [31:0] status_word;
	logic [31:0] rd_word;
	logic        rd_hit;
	logic        wr_ctl;
	logic        wr_evt;
	logic        wr_hit;

	// Load sequence: key bytes, then option byte, then run
	always_comb begin
		case (state)
		crl_pkg::CRL_S_KEY_REQ:  next_state = crl_pkg::CRL_S_KEY_WAIT;
		crl_pkg::CRL_S_KEY_WAIT: next_state = (load_idx == `CRL_KEY_LAST_IDX)
			? crl_pkg::CRL_S_LCK_REQ : crl_pkg::CRL_S_KEY_REQ;
		crl_pkg::CRL_S_LCK_REQ:  next_state = crl_pkg::CRL_S_LCK_WAIT;
		crl_pkg::CRL_S_LCK_WAIT: next_state = crl_pkg::CRL_S_RUN;
		crl_pkg::CRL_S_RUN:      next_state = crl_pkg::CRL_S_RUN;
		default:                 next_state = crl_pkg::CRL_S_KEY_REQ;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= crl_pkg::CRL_S_KEY_REQ;
			load_idx <= '0;
		end else begin
			state <= next_state;
			if (state == crl_pkg::CRL_S_KEY_WAIT) begin
				load_idx <= load_idx + 6'h01;
			end
		end
	end

	// Store addresses follow the image layout
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nvm_req <= 1'b0;
			nvm_addr <= `CRL_KEY_BASE;
		end else begin
			nvm_req <= (next_state == crl_pkg::CRL_S_KEY_WAIT) ||
				(next_state == crl_pkg::CRL_S_LCK_WAIT);
			nvm_addr <= (next_state == crl_pkg::CRL_S_LCK_WAIT) ?
				`CRL_LOCK_ADDR : (`CRL_KEY_BASE | {10'h000, load_idx});
		end
	end

	// Option byte is captured once and never touched while running
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock_byte <= `CRL_LOCK_RESET;
		end else if (state == crl_pkg::CRL_S_LCK_WAIT) begin
			lock_byte <= nvm_data;
		end
	end

	assign key_wr  = (state == crl_pkg::CRL_S_KEY_WAIT);
	assign running = (state == crl_pkg::CRL_S_RUN);

	// Zero enables; a lone lock two is undefined, treated as verify off
	assign lock.lock1 = ~lock_byte[`CRL_LOCK1_BIT];
	assign lock.lock2 = ~lock_byte[`CRL_LOCK2_BIT];
	assign lock.bad_combo = lock.lock2 & ~lock.lock1;

	crl_key_store u_key (
		.aclk           (aclk),
		.aresetn        (aresetn),
		.wr_en          (key_wr),
		.wr_idx         (load_idx),
		.wr_data        (nvm_data),
		.rd_idx         (ver_addr[`CRL_KEY_IW-1:0]),
		.rd_data        (key_byte),
		.any_programmed (key_any)
	);

	// Pin passes two flops; latch taken on the edge that enters run
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_latched <= 1'b0;
		end else begin
			ext_s1 <= ext_access_pin;
			ext_s2 <= ext_s1;
			if (state == crl_pkg::CRL_S_LCK_WAIT) begin
				ext_latched <= ext_s2;
			end
		end
	end

	assign external_access_select = lock.lock1 ? ext_latched : ext_s2;

	// Table reads from external code may not touch internal bytes under lock one or before run
	assign table_read_block = code_table_read_instruction &
		fetch_from_external &
		(lock.lock1 | ~running);

	// Verify pipeline: address flop, memory cycle, result flop
	assign ver_ready = running & ~ver_pend;
	assign ver_take  = ver_req & ver_ready;
	assign ver_blk   = lock.lock2 | ~control[`CRL_CT_VER_EN] |
		(ver_addr > `CRL_ROM_TOP);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ver_pend <= 1'b0;
			ver_q <= '0;
			rom_addr <= '0;
		end else begin
			ver_pend <= ver_take;
			if (ver_take) begin
				rom_addr <= ver_addr[`CRL_ROM_AW-1:0];
				ver_q.denied <= ver_blk;
				ver_q.key <= key_byte;
			end
		end
	end

	// All-ones key leaves the byte plain, any other key scrambles
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ver_valid <= 1'b0;
			ver_denied <= 1'b0;
			ver_data <= 8'h00;
		end else begin
			ver_valid <= ver_pend;
			if (ver_pend) begin
				ver_denied <= ver_q.denied;
				ver_data <= ver_q.denied ? 8'h00 :
					~(rom_data ^ ver_q.key);
			end
		end
	end

	// Programming is closed for good once lock one is set
	assign prog_ok = running & control[`CRL_CT_PROG_EN] & ~lock.lock1;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prog_ack <= 1'b0;
			prog_refused <= 1'b0;
			code_wr_en <= 1'b0;
			code_wr_addr <= 16'h0000;
			code_wr_data <= 8'h00;
		end else begin
			prog_ack <= prog_req & prog_ok;
			prog_refused <= prog_req & ~prog_ok;
			code_wr_en <= prog_req & prog_ok;
			if (prog_req & prog_ok) begin
				code_wr_addr <= prog_addr;
				code_wr_data <= prog_data;
			end
		end
	end

	// AXI write: address and data held separately, reply after both
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
	assign wr_do  = aw_held & w_held & ~s_axi_bvalid;
	assign wr_ctl = wr_do && ({aw_q[31:`CRL_ADDR_LSB], 2'h0} == `CRL_REG_CONTROL);
	assign wr_evt = wr_do && ({aw_q[31:`CRL_ADDR_LSB], 2'h0} == `CRL_REG_EVENTS);
	assign wr_hit = wr_ctl | wr_evt |
		({aw_q[31:`CRL_ADDR_LSB], 2'h0} == `CRL_REG_STATUS);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_q <= 32'h0000_0000;
			w_q <= 32'h0000_0000;
			ws_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CRL_RESP_OKAY;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_held <= 1'b1;
				aw_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_held <= 1'b1;
				w_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end
			if (wr_do) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `CRL_RESP_OKAY : `CRL_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Control steers the ports; a hardware event beats a same-cycle clear
	assign ev_set = {table_read_block, ver_take & ver_blk,
		prog_req & ~prog_ok};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			control <= `CRL_CONTROL_RESET;
			events <= 3'h0;
		end else begin
			if (wr_ctl && ws_q[0]) begin
				control <= w_q[1:0];
			end
			events <= (events & ~((wr_evt && ws_q[0]) ? w_q[2:0] : 3'h0))
				| ev_set;
		end
	end

	// Status reflects the loaded protection state
	assign status_word = {26'h0, lock.bad_combo, running,
		external_access_select, key_any, lock.lock2, lock.lock1};
	assign rd_hit = ({s_axi_araddr[31:`CRL_ADDR_LSB], 2'h0} == `CRL_REG_STATUS)
		|| ({s_axi_araddr[31:`CRL_ADDR_LSB], 2'h0} == `CRL_REG_CONTROL)
		|| ({s_axi_araddr[31:`CRL_ADDR_LSB], 2'h0} == `CRL_REG_EVENTS);
	assign rd_word =
		({s_axi_araddr[31:2], 2'h0} == `CRL_REG_STATUS)  ? status_word :
		({s_axi_araddr[31:2], 2'h0} == `CRL_REG_CONTROL) ? {30'h0, control} :
		({s_axi_araddr[31:2], 2'h0} == `CRL_REG_EVENTS)  ? {29'h0, events} :
		32'h0000_0000;
	assign s_axi_arready = ~s_axi_rvalid;

	// Read answers one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `CRL_RESP_OKAY;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? `CRL_RESP_OKAY : `CRL_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Checks
	property p_verify_open;
		@(posedge aclk) disable iff (!aresetn)
		ver_take && !lock.lock1 && !lock.lock2 && control[`CRL_CT_VER_EN]
		&& ver_addr <= `CRL_ROM_TOP |-> ##2 ver_valid && !ver_denied;
	endproperty
	a_verify_open: assert property (p_verify_open)
		else $error("open verify was denied");

	property p_scramble;
		@(posedge aclk) disable iff (!aresetn)
		ver_take && !ver_blk |-> ##2
		ver_data == ~($past(rom_data) ^ $past(key_byte, 2));
	endproperty
	a_scramble: assert property (p_scramble)
		else $error("verify byte is not data xnor key");

	property p_key_idx;
		@(posedge aclk) disable iff (!aresetn)
		ver_take |=> ver_q.key == $past(key_byte);
	endproperty
	a_key_idx: assert property (p_key_idx)
		else $error("wrong key byte captured");

	property p_tbl_read;
		@(posedge aclk) disable iff (!aresetn)
		running |-> table_read_block == (code_table_read_instruction &&
		fetch_from_external && lock.lock1);
	endproperty
	a_tbl_read: assert property (p_tbl_read)
		else $error("table read gating wrong");

	property p_xsel_hold;
		@(posedge aclk) disable iff (!aresetn)
		running && $past(running) && lock.lock1 |->
		$stable(external_access_select);
	endproperty
	a_xsel_hold: assert property (p_xsel_hold)
		else $error("latched external access changed");

	property p_prog_lock;
		@(posedge aclk) disable iff (!aresetn)
		prog_req && lock.lock1 |=> prog_refused && !code_wr_en;
	endproperty
	a_prog_lock: assert property (p_prog_lock)
		else $error("programming accepted under lock");

	property p_verify_off;
		@(posedge aclk) disable iff (!aresetn)
		ver_take && lock.lock2 |-> ##2 ver_valid && ver_denied
		&& ver_data == 8'h00;
	endproperty
	a_verify_off: assert property (p_verify_off)
		else $error("verify allowed with both locks");

	property p_key_fresh;
		@(posedge aclk) disable iff (!aresetn)
		state == crl_pkg::CRL_S_KEY_REQ && load_idx == 6'h00 |-> !key_any;
	endproperty
	a_key_fresh: assert property (p_key_fresh)
		else $error("key not all ones after reset");

	property p_lock_stable;
		@(posedge aclk) disable iff (!aresetn)
		running && $past(running) |-> $stable(lock_byte) && $stable(key_any);
	endproperty
	a_lock_stable: assert property (p_lock_stable)
		else $error("protection state changed while running");

	c_denied:  cover property (@(posedge aclk) ver_valid && ver_denied);
	c_scrmbl:  cover property (@(posedge aclk) ver_valid && key_any);
	c_blocked: cover property (@(posedge aclk) table_read_block && running);
	c_refused: cover property (@(posedge aclk) prog_refused);

endmodule

// file: bench/crl_nvm_model.sv
// Behavioural option store and code memory facing the lock block
`timescale 1ns/1ps
`include "crl_defines.svh"

module crl_nvm_model (
	// Clock
	input  wire logic         aclk,
	// Option store read port
	input  wire logic         nvm_req,
	input  wire logic [15:0]  nvm_addr,
	output logic      [7:0]   nvm_data,
	// Code memory read port
	input  wire logic [12:0]  rom_addr,
	output logic      [7:0]   rom_data,
	// Image contents chosen by the bench
	input  wire logic [7:0]   lock_cfg,
	input  wire logic         key_on
);
	logic [7:0] idle_q;

	// The block samples at the end of the request cycle, so both stores
	// answer within that cycle; an idle line toggles every cycle so that
	// a sample taken outside a request never passes for good data
	always @(posedge aclk) begin
		idle_q <= ~idle_q;
	end

	always_comb begin
		if (nvm_req === 1'b1 && nvm_addr === `CRL_LOCK_ADDR)
			nvm_data = lock_cfg;
		else if (nvm_req === 1'b1 && nvm_addr[15:6] === 10'h080)
			nvm_data = key_on ? {2'b01, nvm_addr[5:0]} : 8'hff;
		else
			nvm_data = idle_q;
	end

	// Code memory pattern depends on the address only
	assign rom_data = rom_addr[7:0] ^ 8'ha5;

	initial idle_q = 8'h00;
endmodule

// file: bench/tb_crl_top.sv
// Self-checking bench for the code lock block
`timescale 1ns/1ps
`include "crl_defines.svh"

module tb_crl_top;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, nvm_req, key_on;
	logic ext_access_pin, external_access_select, table_read_block;
	logic code_table_read_instruction, fetch_from_external, ver_req;
	logic ver_ready, ver_valid, ver_denied, prog_req, prog_ack;
	logic prog_refused, code_wr_en;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [15:0] nvm_addr, ver_addr, prog_addr, code_wr_addr;
	logic [7:0]  nvm_data, ver_data, rom_data, prog_data, code_wr_data;
	logic [7:0]  lock_cfg;
	logic [12:0] rom_addr;
	int          errors, compares, cycles;

	crl_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nvm_req, .nvm_addr,
		.nvm_data, .ext_access_pin, .external_access_select,
		.code_table_read_instruction, .fetch_from_external, .table_read_block,
		.ver_req, .ver_addr, .ver_ready, .ver_valid, .ver_data,
		.ver_denied, .rom_addr, .rom_data, .prog_req, .prog_addr,
		.prog_data, .prog_ack, .prog_refused, .code_wr_en, .code_wr_addr,
		.code_wr_data);

	crl_nvm_model u_nvm (.aclk, .nvm_req, .nvm_addr, .nvm_data, .rom_addr,
		.rom_data, .lock_cfg, .key_on);

	// Clock, 8 ns period
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	// Hang guard, far above the fewer than one thousand cycles the run needs
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			results();
		end
	end

	task check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("ERROR at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task results();
		$display("Comparisons %0d, mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Write address and data offered together, each dropped once taken
	task axi_wr(input logic [31:0] a, input logic [31:0] d,
		output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
	endtask

	task axi_rd(input logic [31:0] a, output logic [31:0] d,
		output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask

	// Reset with a chosen image, then poll until the load has finished
	task boot(input logic [7:0] lk, input logic ky, input logic pin);
		logic [31:0] d;
		logic [1:0]  r;
		lock_cfg <= lk;
		key_on <= ky;
		ext_access_pin <= pin;
		aresetn <= 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		do axi_rd(`CRL_REG_STATUS, d, r);
		while (d[`CRL_ST_LOADED] !== 1'b1);
		ext_access_pin <= ~pin;
		repeat (6) @(posedge aclk);
	endtask

	// One verify read: request held until accepted, answer two cycles on
	task verify(input logic [15:0] a, input logic [7:0] exp,
		input logic den);
		ver_addr <= a;
		ver_req <= 1'b1;
		do @(posedge aclk);
		while (ver_ready !== 1'b1);
		ver_req <= 1'b0;
		do @(posedge aclk);
		while (ver_valid !== 1'b1);
		check(ver_data, exp);
		check(ver_denied, den);
	endtask

	// One programming request, answer sampled the cycle after
	task prog_try(input logic ok);
		prog_addr <= 16'h0010;
		prog_data <= 8'h3c;
		prog_req <= 1'b1;
		@(posedge aclk);
		prog_req <= 1'b0;
		@(posedge aclk);
		check({prog_ack, code_wr_en, prog_refused}, {ok, ok, ~ok});
	endtask

	task fetch_check(input logic exp);
		code_table_read_instruction <= 1'b1;
		fetch_from_external <= 1'b1;
		repeat (2) @(posedge aclk);
		check(table_read_block, exp);
		code_table_read_instruction <= 1'b0;
		repeat (2) @(posedge aclk);
		check(table_read_block, 1'b0);
	endtask

	// No locks, no key: plain readout, programming allowed, registers
	task sc_open();
		logic [31:0] d;
		logic [1:0]  r;
		boot(8'hff, 1'b0, 1'b1);
		axi_rd(`CRL_REG_STATUS, d, r);
		check(d, 32'h0000_0010);
		check(external_access_select, 1'b0);
		verify(16'h0123, 8'h86, 1'b0);
		verify(16'h2000, 8'h00, 1'b1);
		axi_rd(`CRL_REG_CONTROL, d, r);
		check(d, 32'h0000_0002);
		prog_try(1'b0);
		axi_wr(`CRL_REG_CONTROL, 32'h0000_0003, r);
		check(r, `CRL_RESP_OKAY);
		prog_try(1'b1);
		check({code_wr_addr, code_wr_data}, 24'h00103c);
		fetch_check(1'b0);
		axi_rd(32'h0000_000c, d, r);
		check(d, 32'h0000_0000);
		check(r, `CRL_RESP_SLVERR);
	endtask

	// Key programmed: scrambled verify with the byte of the low address
	task sc_key();
		logic [31:0] d;
		logic [1:0]  r;
		boot(8'hff, 1'b1, 1'b0);
		axi_rd(`CRL_REG_STATUS, d, r);
		check(d, 32'h0000_001c);
		verify(16'h0123, 8'h1a, 1'b0);
		verify(16'h1fff, 8'hda, 1'b0);
	endtask

	// First lock: table reads blocked, pin latched, programming refused
	task sc_lock1();
		logic [31:0] d;
		logic [1:0]  r;
		boot(8'hfe, 1'b0, 1'b1);
		check(external_access_select, 1'b1);
		axi_rd(`CRL_REG_STATUS, d, r);
		check(d, 32'h0000_0019);
		fetch_check(1'b1);
		axi_wr(`CRL_REG_CONTROL, 32'h0000_0003, r);
		prog_try(1'b0);
		axi_rd(`CRL_REG_EVENTS, d, r);
		check(d[`CRL_EV_PROG_REF], 1'b1);
		check(d[`CRL_EV_TBL_BLK], 1'b1);
		axi_wr(`CRL_REG_EVENTS, 32'h0000_0001, r);
		axi_rd(`CRL_REG_EVENTS, d, r);
		check(d[`CRL_EV_PROG_REF], 1'b0);
		verify(16'h0040, 8'he5, 1'b0);
	endtask

	// Both locks: verify denied on any address
	task sc_lock12();
		logic [31:0] d;
		logic [1:0]  r;
		boot(8'hfc, 1'b1, 1'b0);
		axi_rd(`CRL_REG_STATUS, d, r);
		check(d, 32'h0000_0017);
		verify(16'h0123, 8'h00, 1'b1);
		verify(16'h0000, 8'h00, 1'b1);
		axi_rd(`CRL_REG_EVENTS, d, r);
		check(d[`CRL_EV_VER_DEN], 1'b1);
	endtask

	initial begin
		{errors, compares, cycles} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		// Answer channels always ready, so back-to-back calls never
		// lower and raise the same line in one time step
		{s_axi_bready, s_axi_rready} = 2'h3;
		{ver_req, prog_req, key_on, ext_access_pin} = '0;
		{code_table_read_instruction, fetch_from_external} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		s_axi_wstrb = 4'hf;
		{ver_addr, prog_addr, prog_data} = '0;
		lock_cfg = 8'hff;
		aresetn = 1'b0;
		sc_open();
		sc_key();
		sc_lock1();
		sc_lock12();
		results();
	end
endmodule
